// File: logic/lcdcd_core.sv
// Purpose: Column driver core: host bus, display RAM, refresh and segments
// Assumes: All inputs synchronous to sys_clk_in; rst_in synchronous
// Notes:   Host data writes pass through a FIFO drained at the internal rate; instructions apply at once
`timescale 1ns/1ps
`include "lcdcd_regs.svh"

module lcdcd_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   // Drain side
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
   assign rd_valid_out = (count_q != '0);
   assign push         = wr_valid_in & wr_ready_out;
   assign pop          = rd_valid_out & rd_ready_in;
   assign rd_data_out  = mem[rd_ptr_q];

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem[wr_ptr_q] <= wr_data_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // lcdcd_fifo

module lcdcd_core
   import lcdcd_pkg::*;
#(
   parameter int CLK_DIV    = `LCDCD_CLK_DIV,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   // Initialise and segment order, active regardless of selects
   input  wire logic         init_n_in,
   input  wire logic         seg_order_in,
   // Host bus
   input  wire logic         chip_select_low_one_n_in,
   input  wire logic         chip_select_low_two_n_in,
   input  wire logic         chip_select_high_three_in,
   input  wire logic         strobe_in,
   input  wire logic         dir_read_in,
   input  wire logic         data_sel_in,
   input  wire logic [7:0]   bus_lines_in,
   output logic      [7:0]   bus_lines_out,
   output logic              bus_lines_oe_out,
   // Row driver side
   input  wire logic         frame_sync_input_in,
   input  wire logic         line_latch_pulse_in,
   input  wire logic         ac_phase_in,
   // Segment side
   output logic      [63:0]  segment_outputs_out,
   output logic      [127:0] drive_level_selects_out
);
   localparam int DW = 17;

   // Display RAM, one byte per page and column
   logic [7:0]         ram_mem [0:511];

   lcdcd_state_e       state_q;
   logic               disp_on_q;
   logic               init_flag_q;
   logic [5:0]         start_line_q;
   logic [2:0]         page_q;
   logic [5:0]         col_q;
   logic [5:0]         line_q;
   logic [7:0]         out_hold_q;
   logic [63:0]        row_latch_q;
   logic [63:0]        seg_q;
   logic [127:0]       lvl_q;
   logic [7:0]         bus_q;
   logic               strobe_q;
   logic               line_pulse_q;
   logic [7:0]         div_q;
   logic               tick;

   logic               selected;
   logic               strobe_fall;
   logic               is_status;
   logic               accept;
   logic               busy;
   logic               is_onoff;
   logic               is_start;
   logic               is_page;
   logic               is_col;
   logic               is_wr;
   logic               is_rd;
   logic               cl_rise;
   logic               cl_fall;
   logic               fifo_wr_ready;
   logic               fifo_rd_valid;
   logic               fifo_rd_ready;
   logic [DW-1:0]      fifo_rd_data;
   logic [7:0]         status_byte;

   function automatic lcdcd_addr_t ram_addr(input logic [2:0] pg,
                                            input logic [5:0] col);
      return {pg, col};
   endfunction

   // Drive level from latched dot and AC phase
   function automatic logic [1:0] drive_level(input logic dot,
                                              input logic phase);
      logic [1:0] lvl;
      lvl = `LCDCD_LVL_V1;
      unique case ({phase, dot})
         2'h3: lvl = `LCDCD_LVL_V1;
         2'h2: lvl = `LCDCD_LVL_V3;
         2'h1: lvl = `LCDCD_LVL_V2;
         2'h0: lvl = `LCDCD_LVL_V4;
      endcase
      return lvl;
   endfunction

   // Internal rate enable standing in for the two-phase clock
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || div_q == 8'(CLK_DIV - 1)) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   assign tick = (div_q == 8'(CLK_DIV - 1));

   // Host access decode
   assign selected = ~chip_select_low_one_n_in & ~chip_select_low_two_n_in
                     & chip_select_high_three_in;
   assign strobe_fall = strobe_q & ~strobe_in & selected;
   assign is_status   = ~data_sel_in & dir_read_in;
   assign busy        = (state_q != LCDCD_IDLE);
   // Status read never blocked; other accesses need idle, init high
   assign accept = strobe_fall & ~is_status & ~busy
                   & init_n_in & fifo_wr_ready;
   assign is_onoff = accept & ~data_sel_in
                   & (bus_lines_in[7:1] == `LCDCD_ONOFF_CODE);
   assign is_start = accept & ~data_sel_in
                   & (bus_lines_in[7:6] == `LCDCD_START_CODE);
   assign is_page  = accept & ~data_sel_in
                   & (bus_lines_in[7:3] == `LCDCD_PAGE_CODE);
   assign is_col   = accept & ~data_sel_in
                   & (bus_lines_in[7:6] == `LCDCD_COL_CODE);
   assign is_wr    = accept & data_sel_in & ~dir_read_in;
   assign is_rd    = accept & data_sel_in & dir_read_in;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         strobe_q     <= 1'b0;
         line_pulse_q <= 1'b0;
      end else begin
         strobe_q     <= strobe_in;
         line_pulse_q <= line_latch_pulse_in;
      end
   end

   // Executor: busy from acceptance for one to two internal periods
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_q <= LCDCD_IDLE;
      end else begin
         unique case (state_q)
            LCDCD_IDLE: if (accept) state_q <= LCDCD_EXEC;
            LCDCD_EXEC: if (tick) state_q <= LCDCD_DONE;
            LCDCD_DONE: if (tick && !fifo_rd_valid) begin
               state_q <= LCDCD_IDLE;
            end
            default: state_q <= LCDCD_IDLE;
         endcase
      end
   end

   // On/off flag
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !init_n_in) begin
         disp_on_q <= 1'b0;
      end else if (is_onoff) begin
         disp_on_q <= bus_lines_in[`LCDCD_ONOFF_BIT];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         init_flag_q <= 1'b0;
      end else begin
         init_flag_q <= ~init_n_in;
      end
   end

   // Start line
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !init_n_in) begin
         start_line_q <= `LCDCD_START_RST;
      end else if (is_start) begin
         start_line_q <= bus_lines_in[5:0];
      end
   end

   // Page register: no counting
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         page_q <= `LCDCD_PAGE_RST;
      end else if (is_page) begin
         page_q <= bus_lines_in[2:0];
      end
   end

   // Column counter wraps naturally at six bits
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         col_q <= `LCDCD_COL_RST;
      end else if (is_col) begin
         col_q <= bus_lines_in[5:0];
      end else if (is_wr || is_rd) begin
         col_q <= col_q + 6'h01;
      end
   end

   // Writes queue with their address so the counter can move on
   // FIFO entry doubles as the input holding register
   lcdcd_fifo #(
      .WIDTH (DW),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_fifo (
      .sys_clk_in   (sys_clk_in),
      .rst_in       (rst_in),
      .wr_data_in   ({ram_addr(page_q, col_q), bus_lines_in}),
      .wr_valid_in  (is_wr),
      .wr_ready_out (fifo_wr_ready),
      .rd_data_out  (fifo_rd_data),
      .rd_valid_out (fifo_rd_valid),
      .rd_ready_in  (fifo_rd_ready)
   );
   assign fifo_rd_ready = tick;

   always_ff @(posedge sys_clk_in) begin
      if (fifo_rd_valid && fifo_rd_ready) begin
         ram_mem[fifo_rd_data[16:8]] <= fifo_rd_data[7:0];
      end
   end

   // Output holding register reloads only on a data read
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         out_hold_q <= `LCDCD_BYTE_RST;
      end else if (is_rd) begin
         out_hold_q <= ram_mem[ram_addr(page_q, col_q)];
      end
   end

   // Bus output byte
   always_comb begin
      status_byte = 8'h00;
      status_byte[`LCDCD_ST_BUSY_BIT] = busy;
      status_byte[`LCDCD_ST_OFF_BIT]  = ~disp_on_q;
      status_byte[`LCDCD_ST_INIT_BIT] = init_flag_q;
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         bus_q <= `LCDCD_BYTE_RST;
      end else if (data_sel_in && dir_read_in) begin
         bus_q <= out_hold_q;
      end else begin
         bus_q <= status_byte;
      end
   end
   assign bus_lines_out    = bus_q;
   assign bus_lines_oe_out = selected & dir_read_in & strobe_in;

   // Refresh line counter
   assign cl_rise = line_latch_pulse_in & ~line_pulse_q;
   assign cl_fall = ~line_latch_pulse_in & line_pulse_q;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         line_q <= `LCDCD_START_RST;
      end else if (frame_sync_input_in) begin
         line_q <= start_line_q;
      end else if (cl_fall) begin
         line_q <= line_q + 6'h01;
      end
   end

   // Row latch: one bit of every column for the current line
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         row_latch_q <= '0;
      end else if (cl_rise) begin
         for (int c = 0; c < 64; c++) begin
            row_latch_q[c] <=
               ram_mem[ram_addr(line_q[5:3], 6'(c))][line_q[2:0]];
         end
      end
   end

   // Segment drive; order select picks which end is column zero
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         seg_q <= '0;
         lvl_q <= '0;
      end else begin
         for (int s = 0; s < 64; s++) begin
            logic dot;
            dot = disp_on_q & (seg_order_in ? row_latch_q[s]
                                            : row_latch_q[63 - s]);
            seg_q[s]        <= dot;
            lvl_q[2*s +: 2] <= drive_level(dot, ac_phase_in);
         end
      end
   end
   assign segment_outputs_out     = seg_q;
   assign drive_level_selects_out = lvl_q;

endmodule // lcdcd_core

// File: logic/lcdcd_pkg.sv
// Purpose: Shared types of the column core
// Assumes: Nothing beyond the constants header
// Notes:   Executor states are Gray coded along idle, exec, done
package lcdcd_pkg;
   typedef enum logic [1:0] {
      LCDCD_IDLE = 2'h0,
      LCDCD_EXEC = 2'h1,
      LCDCD_DONE = 2'h3
   } lcdcd_state_e;
   typedef logic [8:0] lcdcd_addr_t;
endpackage

// File: logic/lcdcd_regs.svh
// Purpose: Named codes, bit positions and reset values for the column core
// Assumes: Included by bare name from lcdcd_core.sv and the bench top, not from lcdcd_pkg.sv
// Notes:   Definitions only
`ifndef LCDCD_REGS_SVH
`define LCDCD_REGS_SVH

// Instruction prefixes, compared against the top bits of the bus byte
`define LCDCD_ONOFF_CODE   7'h1F
`define LCDCD_START_CODE   2'h3
`define LCDCD_PAGE_CODE    5'h17
`define LCDCD_COL_CODE     2'h1

// Field positions in the bus byte
`define LCDCD_ONOFF_BIT    0
`define LCDCD_ST_BUSY_BIT  7
`define LCDCD_ST_OFF_BIT   5
`define LCDCD_ST_INIT_BIT  4

// Reset values and last column index
`define LCDCD_START_RST    6'h00
`define LCDCD_PAGE_RST     3'h0
`define LCDCD_COL_RST      6'h00
`define LCDCD_BYTE_RST     8'h00
`define LCDCD_LAST_COL     6'h3F

// Internal clock divider and drive level codes
`define LCDCD_CLK_DIV      4
`define LCDCD_LVL_V1       2'h0
`define LCDCD_LVL_V2       2'h1
`define LCDCD_LVL_V3       2'h2
`define LCDCD_LVL_V4       2'h3

`endif

// File: tb/lcdcd_core_monitor.sv
// Purpose: Port-level checks on the column core
// Assumes: Sees only the core's ports; one clock domain
// Notes:   Bound into every lcdcd_core instance
`timescale 1ns/1ps
module lcdcd_core_monitor #(
   parameter int CLK_DIV    = 4,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic         sys_clk_in,
   input wire logic         rst_in,
   // Host side, AC phase and segment outputs
   input wire logic         init_n_in,
   input wire logic         chip_select_low_one_n_in,
   input wire logic         chip_select_low_two_n_in,
   input wire logic         chip_select_high_three_in,
   input wire logic         strobe_in,
   input wire logic         dir_read_in,
   input wire logic         data_sel_in,
   input wire logic         ac_phase_in,
   input wire logic [7:0]   bus_lines_out,
   input wire logic         bus_lines_oe_out,
   input wire logic [63:0]  segment_outputs_out,
   input wire logic [127:0] drive_level_selects_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic sel, st, dr;
   assign sel = !chip_select_low_one_n_in && !chip_select_low_two_n_in
                && chip_select_high_three_in;
   assign st = sel && !data_sel_in && dir_read_in && strobe_in;
   assign dr = sel && data_sel_in && dir_read_in && strobe_in;

   oe_on_a: assert property (sel && dir_read_in && strobe_in |->
      bus_lines_oe_out) else $error("bus not driven on read");
   oe_off_a: assert property (!(sel && dir_read_in && strobe_in) |->
      !bus_lines_oe_out) else $error("bus driven while not read");
   status_zero_a: assert property (st [*3] |->
      bus_lines_out[6] == 1'b0 && bus_lines_out[3:0] == 4'h0)
      else $error("status spare bits not zero");
   init_flag_a: assert property ((st && !init_n_in) [*3] |->
      bus_lines_out[5:4] == 2'b11) else $error("init status wrong");
   off_dark_a: assert property ((st && bus_lines_out[5]) [*3] |->
      segment_outputs_out == 64'h0) else $error("segments lit while off");
   held_read_a: assert property (dr [*3] |->
      $stable(bus_lines_out)) else $error("read byte moved mid strobe");
   level_lo_a: assert property (!$past(rst_in) && $stable(ac_phase_in) |->
      drive_level_selects_out[1:0] == {~segment_outputs_out[0], ~ac_phase_in})
      else $error("segment 0 level wrong");
   level_hi_a: assert property (ac_phase_in [*2] |->
      drive_level_selects_out[127:126] == {~segment_outputs_out[63], 1'b0})
      else $error("segment 63 level wrong");

   cover property (dr ##1 !strobe_in);
   cover property (st && bus_lines_out[7]);
   cover property (segment_outputs_out != 64'h0);
endmodule // lcdcd_core_monitor

bind lcdcd_core lcdcd_core_monitor #(
   .CLK_DIV(CLK_DIV), .FIFO_DEPTH(FIFO_DEPTH)) u_mon (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .init_n_in(init_n_in),
   .chip_select_low_one_n_in(chip_select_low_one_n_in),
   .chip_select_low_two_n_in(chip_select_low_two_n_in),
   .chip_select_high_three_in(chip_select_high_three_in),
   .strobe_in(strobe_in), .dir_read_in(dir_read_in),
   .data_sel_in(data_sel_in), .ac_phase_in(ac_phase_in),
   .bus_lines_out(bus_lines_out), .bus_lines_oe_out(bus_lines_oe_out),
   .segment_outputs_out(segment_outputs_out),
   .drive_level_selects_out(drive_level_selects_out));

// File: tb/lcdcd_host_model.sv
// Purpose: Host bus model on the far side of the column core
// Assumes: Requests change on the falling clock edge
// Notes:   Released bus lines show the inverse of the last byte
`timescale 1ns/1ps
module lcdcd_host_model (
   // Clock
   input  wire logic       sys_clk_in,
   // Bus controls
   output logic            cs_one_n_out,
   output logic            cs_two_n_out,
   output logic            cs_three_out,
   output logic            strobe_out,
   output logic            dir_read_out,
   output logic            data_sel_out,
   // Data lines
   input  wire logic [7:0] core_byte_in,
   input  wire logic       core_oe_in,
   output logic      [7:0] bus_byte_out,
   output logic            stuck_out
);
   logic [7:0] drv_q;
   assign bus_byte_out = core_oe_in ? core_byte_in : drv_q;
   initial begin
      {cs_one_n_out, cs_two_n_out, cs_three_out} = 3'b110;
      {strobe_out, dir_read_out, data_sel_out, stuck_out} = 4'h0;
      drv_q = 8'h00;
   end
   // Held through the strobe fall, released one edge later
   task automatic xfer(input logic d, r, en, input logic [7:0] b,
                       output logic [7:0] q);
      @(negedge sys_clk_in);
      {cs_one_n_out, cs_two_n_out, cs_three_out} = {2'b00, en};
      {data_sel_out, dir_read_out} = {d, r};
      drv_q = r ? ~drv_q : b;
      strobe_out = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      q = bus_byte_out;
      strobe_out = 1'b0;
      @(negedge sys_clk_in);
      cs_three_out = 1'b0;
      drv_q = ~drv_q;
   endtask
   // Polls up to 40 times until neither busy nor initialising
   task automatic cmd(input logic d, r, input logic [7:0] b,
                      output logic [7:0] q);
      logic [7:0] s;
      int n;
      xfer(d, r, 1'b1, b, q);
      n = 0;
      s = 8'hFF;
      while ((s[7] !== 1'b0 || s[4] !== 1'b0) && n < 40) begin
         xfer(1'b0, 1'b1, 1'b1, 8'h00, s);
         n++;
      end
      if (s[7] !== 1'b0 || s[4] !== 1'b0) stuck_out = 1'b1;
   endtask
endmodule // lcdcd_host_model

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the column core
// Assumes: Inputs change on the falling clock edge
// Notes:   RAM is never cleared, so only written columns are compared
`timescale 1ns/1ps
`include "lcdcd_regs.svh"
`define CHK(got, exp, msg) begin total_checks++; \
   if ((got) !== (exp)) begin error_cnt++; \
   $display("MISMATCH %0t %s", $time, msg); end end
module tb_top;
   logic sys_clk_in = 1'b0, rst_in = 1'b1, init_n_in = 1'b1;
   logic seg_order_in = 1'b1, fs = 1'b0, lp = 1'b0, ac = 1'b0;
   logic cs1_n, cs2_n, cs3, strobe, dir_rd, dsel, oe, stuck;
   logic [7:0] bus_in, bus_out, q;
   logic [63:0] seg;
   logic [127:0] lvl;
   int error_cnt = 0, total_checks = 0;
   always #2.5 sys_clk_in = ~sys_clk_in;

   lcdcd_core uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .init_n_in(init_n_in), .seg_order_in(seg_order_in),
      .chip_select_low_one_n_in(cs1_n), .chip_select_low_two_n_in(cs2_n),
      .chip_select_high_three_in(cs3), .strobe_in(strobe),
      .dir_read_in(dir_rd), .data_sel_in(dsel), .bus_lines_in(bus_in),
      .bus_lines_out(bus_out), .bus_lines_oe_out(oe),
      .frame_sync_input_in(fs), .line_latch_pulse_in(lp),
      .ac_phase_in(ac), .segment_outputs_out(seg),
      .drive_level_selects_out(lvl));
   lcdcd_host_model u_host (.sys_clk_in(sys_clk_in), .cs_one_n_out(cs1_n),
      .cs_two_n_out(cs2_n), .cs_three_out(cs3), .strobe_out(strobe),
      .dir_read_out(dir_rd), .data_sel_out(dsel), .core_byte_in(bus_out),
      .core_oe_in(oe), .bus_byte_out(bus_in), .stuck_out(stuck));

   task automatic report_and_stop;
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Optional frame sync, then one full line pulse
   task automatic line(input logic frame);
      @(negedge sys_clk_in);
      fs = frame;
      repeat (2) @(negedge sys_clk_in);
      fs = 1'b0;
      lp = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      lp = 1'b0;
      repeat (4) @(negedge sys_clk_in);
   endtask
   task automatic t_init;
      @(negedge sys_clk_in);
      init_n_in = 1'b0;
      u_host.xfer(1'b0, 1'b0, 1'b1, 8'h3F, q); // display on, ignored
      u_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
      `CHK(q, 8'h30, "status during init")
      @(negedge sys_clk_in);
      init_n_in = 1'b1;
      u_host.cmd(1'b0, 1'b1, 8'h00, q);
      u_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
      `CHK(q, 8'h20, "still off after init")
   endtask
   task automatic t_ram;
      logic [7:0] exp [3] = '{8'hA5, 8'h3C, 8'h81};
      u_host.cmd(1'b0, 1'b0, 8'hBD, q);
      u_host.cmd(1'b0, 1'b0, 8'h7E, q);
      u_host.cmd(1'b1, 1'b0, exp[0], q);
      u_host.cmd(1'b0, 1'b0, 8'h3F, q);
      u_host.cmd(1'b1, 1'b0, exp[1], q);
      u_host.cmd(1'b1, 1'b0, exp[2], q);
      u_host.xfer(1'b0, 1'b0, 1'b0, 8'h40, q);
      u_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
      `CHK(q, 8'h00, "status on and idle")
      u_host.xfer(1'b0, 1'b0, 1'b1, 8'h7E, q);
      u_host.xfer(1'b0, 1'b0, 1'b1, 8'h40, q);
      u_host.cmd(1'b0, 1'b1, 8'h00, q);
      u_host.cmd(1'b1, 1'b1, 8'h00, q);
      for (int i = 0; i < 3; i++) begin
         u_host.cmd(1'b1, 1'b1, 8'h00, q);
         `CHK(q, exp[i], "read back")
      end
   endtask
   task automatic t_disp;
      logic [2:0] exp [3] = '{3'b011, 3'b000, 3'b110};
      u_host.xfer(1'b0, 1'b0, 1'b1, 8'hE8, q);
      u_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
      `CHK(q[7], 1'b1, "busy after command")
      u_host.cmd(1'b0, 1'b1, 8'h00, q);
      for (int i = 0; i < 3; i++) begin
         line(i == 0);
         `CHK({seg[63], seg[62], seg[0]}, exp[i], "line")
      end
      seg_order_in = 1'b0;
      line(1'b1);
      `CHK({seg[63], seg[1], seg[0]}, 3'b110, "reversed")
      `CHK(lvl[3:2], `LCDCD_LVL_V2, "phase low lit")
      @(negedge sys_clk_in);
      ac = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      `CHK(lvl[3:2], `LCDCD_LVL_V1, "phase high lit")
      u_host.cmd(1'b0, 1'b0, 8'h3E, q);
      line(1'b1);
      u_host.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
      `CHK({seg[1], lvl[3:2]}, {1'b0, `LCDCD_LVL_V3}, "dark when off")
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk_in);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(negedge sys_clk_in);
      rst_in = 1'b0;
      t_init();
      t_ram();
      t_disp();
      `CHK(stuck, 1'b0, "busy never cleared")
      report_and_stop();
   end
endmodule // tb_top
